// file: pkg/scfg_defines.svh
`ifndef SCFG_DEFINES_SVH
`define SCFG_DEFINES_SVH

`define SCFG_OFF_CONFIG        8'h02
`define SCFG_OFF_SERIAL_HIGH   8'hFB
`define SCFG_OFF_SERIAL_MID    8'hFC
`define SCFG_OFF_SERIAL_LOW    8'hFD
`define SCFG_OFF_MAKER_ID      8'hFE
`define SCFG_OFF_IRQ_STATUS    8'hE0
`define SCFG_OFF_IRQ_CLEAR     8'hE1
`define SCFG_OFF_IRQ_ENABLE    8'hE2

`define SCFG_BIT_SOFT_RESET    15
`define SCFG_BIT_HEATER        13
`define SCFG_BIT_SEQ_ACQUIRE   12
`define SCFG_BIT_LOW_SUPPLY    11
`define SCFG_BIT_TEMP_RES      10
`define SCFG_BIT_HUM_RES_HI    9
`define SCFG_BIT_HUM_RES_LO    8

`define SCFG_CONFIG_RESET      16'h0000
`define SCFG_CONFIG_WR_MASK    16'h3700
`define SCFG_SERIAL_LOW_MASK   16'hFF80

`define SCFG_IRQ_SOFT_RESET    0
`define SCFG_IRQ_SUPPLY_CHANGE 1
`define SCFG_IRQ_WIDTH         2

`define SCFG_SERIAL_DEFAULT    41'h000_0000_0001
`define SCFG_MAKER_DEFAULT     16'h0A5C

`endif

// file: pkg/scfg_pkg.sv
package scfg_pkg;

	typedef enum logic [1:0] {
		SCFG_HUM_14 = 2'b00,
		SCFG_HUM_11 = 2'b01,
		SCFG_HUM_8  = 2'b10,
		SCFG_HUM_RSV = 2'b11
	} scfg_hum_res_t;

	typedef enum logic [1:0] {
		SCFG_ST_RUN   = 2'b00,
		SCFG_ST_RESET = 2'b01
	} scfg_state_t;

endpackage

// file: pkg/scfg_rd_if.sv
`timescale 1ns/10ps
interface scfg_rd_if;
	logic [7:0]  addr;
	logic [15:0] data;
	logic        hit;

	modport master (output addr, input data, input hit);
	modport slave  (input addr, output data, output hit);
endinterface

// file: rtl/scfg_id_rom.sv
`timescale 1ns/10ps
`include "scfg_defines.svh"
module scfg_id_rom
	import scfg_pkg::*;
#(
	parameter logic [40:0] SERIAL_NUMBER = `SCFG_SERIAL_DEFAULT,
	// arbitrary neutral code, not any real maker
	parameter logic [15:0] MAKER_CODE    = `SCFG_MAKER_DEFAULT
) (
	scfg_rd_if.slave rd
);
	wire [15:0] ser_high = SERIAL_NUMBER[40:25];
	wire [15:0] ser_mid  = SERIAL_NUMBER[24:9];
	// low seven bits are hard zero
	wire [15:0] ser_low  = {SERIAL_NUMBER[8:0], 7'h00};

	assign rd.hit  = (rd.addr == `SCFG_OFF_SERIAL_HIGH) || (rd.addr == `SCFG_OFF_SERIAL_MID)
		|| (rd.addr == `SCFG_OFF_SERIAL_LOW) || (rd.addr == `SCFG_OFF_MAKER_ID);
	assign rd.data = (rd.addr == `SCFG_OFF_SERIAL_HIGH) ? ser_high :
		(rd.addr == `SCFG_OFF_SERIAL_MID) ? ser_mid :
		(rd.addr == `SCFG_OFF_SERIAL_LOW) ? ser_low :
		(rd.addr == `SCFG_OFF_MAKER_ID) ? MAKER_CODE : 16'h0000;
endmodule

// file: rtl/scfg_regs.sv
// The strobed register port was left to the implementer.
`timescale 1ns/10ps
`include "scfg_defines.svh"
module scfg_regs
	import scfg_pkg::*;
#(
	parameter logic [40:0] SERIAL_NUMBER = `SCFG_SERIAL_DEFAULT,
	// arbitrary neutral code, not any real maker
	parameter logic [15:0] MAKER_CODE    = `SCFG_MAKER_DEFAULT
) (
	input  wire logic        clk,
	input  wire logic        resetn,
	input  wire logic [7:0]  addr,
	input  wire logic [15:0] wdata,
	input  wire logic        wr,
	input  wire logic        rd,
	output logic      [15:0] rdata,
	input  wire logic        supply_low,
	output logic             soft_reset,
	output logic             heater_enable,
	output logic             sequential_acquire_select,
	output logic             temp_res_11bit,
	output logic      [1:0]  hum_res,
	output logic             irq
);
	scfg_rd_if rom_bus();

	logic [15:0]                  cfg;
	logic                         supply_seen;
	logic [`SCFG_IRQ_WIDTH-1:0]   irq_status;
	logic [`SCFG_IRQ_WIDTH-1:0]   irq_enable;
	scfg_state_t                  state;

	scfg_id_rom #(
		.SERIAL_NUMBER (SERIAL_NUMBER),
		.MAKER_CODE    (MAKER_CODE)
	) u_rom (
		.rd (rom_bus.slave)
	);

	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		hit = (a == off);
	endfunction

	wire        wr_cfg   = wr && hit(addr, `SCFG_OFF_CONFIG);
	wire        wr_clr   = wr && hit(addr, `SCFG_OFF_IRQ_CLEAR);
	wire        wr_en    = wr && hit(addr, `SCFG_OFF_IRQ_ENABLE);
	wire        sw_reset = wr_cfg && wdata[`SCFG_BIT_SOFT_RESET];
	// only heater, mode and resolution bits are writable; reserved and status ignored
	wire [15:0] next_cfg = wdata & `SCFG_CONFIG_WR_MASK;
	wire        supply_chg = supply_low != supply_seen;
	wire [`SCFG_IRQ_WIDTH-1:0] ev = {supply_chg, sw_reset};
	wire [`SCFG_IRQ_WIDTH-1:0] next_status = (irq_status & ~(wr_clr ?
		wdata[`SCFG_IRQ_WIDTH-1:0] : '0)) | ev;
	// status bit is live, never stored, so it tracks the supply pin
	wire [15:0] cfg_view = {1'b0, cfg[14:12], supply_low, cfg[10:0]};

	assign rom_bus.addr = addr;

	wire [15:0] next_rdata =
		hit(addr, `SCFG_OFF_CONFIG)     ? cfg_view :
		hit(addr, `SCFG_OFF_IRQ_STATUS) ? {14'h0000, irq_status} :
		hit(addr, `SCFG_OFF_IRQ_ENABLE) ? {14'h0000, irq_enable} :
		rom_bus.hit                     ? rom_bus.data : 16'h0000;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state <= SCFG_ST_RUN;
		end else begin
			case (state)
				SCFG_ST_RUN: begin
					if (sw_reset) begin
						state <= SCFG_ST_RESET;
					end
				end
				SCFG_ST_RESET: begin
					state <= SCFG_ST_RUN;
				end
				default: begin
					state <= SCFG_ST_RUN;
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cfg <= `SCFG_CONFIG_RESET;
		end else if (sw_reset) begin
			// soft reset returns config to defaults; bit 15 never stored
			cfg <= `SCFG_CONFIG_RESET;
		end else if (wr_cfg) begin
			cfg <= next_cfg;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			supply_seen <= 1'b0;
			irq_status  <= '0;
			irq_enable  <= '0;
		end else begin
			supply_seen <= supply_low;
			irq_status  <= next_status;
			if (wr_en) begin
				irq_enable <= wdata[`SCFG_IRQ_WIDTH-1:0];
			end
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rdata                     <= 16'h0000;
			soft_reset                <= 1'b0;
			heater_enable             <= 1'b0;
			sequential_acquire_select <= 1'b0;
			temp_res_11bit            <= 1'b0;
			hum_res                   <= SCFG_HUM_14;
			irq                       <= 1'b0;
		end else begin
			rdata                     <= rd ? next_rdata : 16'h0000;
			soft_reset                <= sw_reset;
			heater_enable             <= cfg[`SCFG_BIT_HEATER];
			sequential_acquire_select <= cfg[`SCFG_BIT_SEQ_ACQUIRE];
			temp_res_11bit            <= cfg[`SCFG_BIT_TEMP_RES];
			hum_res                   <= cfg[`SCFG_BIT_HUM_RES_HI:`SCFG_BIT_HUM_RES_LO];
			irq                       <= |(next_status & irq_enable);
		end
	end
endmodule

// file: bench/scfg_host.sv
`timescale 1ns/10ps
module scfg_host (
	input  wire logic        clk,
	output logic      [7:0]  addr,
	output logic      [15:0] wdata,
	output logic             wr,
	output logic             rd,
	input  wire logic [15:0] rdata
);
	initial {addr, wdata, wr, rd} = '0;
	task automatic put(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= (a == 8'h02) ? d & 16'hff00 : d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		// released lines flip so stale values never look valid
		addr <= ~a;
		wdata <= ~d;
	endtask
	task automatic get(input logic [7:0] a, output logic [15:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		addr <= ~a;
		@(negedge clk);
		d = rdata;
	endtask
endmodule

// file: bench/scfg_regs_chk.sv
`timescale 1ns/10ps
module scfg_regs_chk #(
	parameter logic [40:0] SERIAL_NUMBER = 41'h000_0000_0001,
	parameter logic [15:0] MAKER_CODE    = 16'h0a5c
) (
	input wire logic        clk,
	input wire logic        resetn,
	input wire logic [7:0]  addr,
	input wire logic [15:0] wdata,
	input wire logic        wr,
	input wire logic        rd,
	input wire logic [15:0] rdata,
	input wire logic        supply_low,
	input wire logic        soft_reset,
	input wire logic        sequential_acquire_select,
	input wire logic        temp_res_11bit,
	input wire logic [1:0]  hum_res
);
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	chk_serial_high: assert property (rd && addr == 8'hfb |=> rdata == SERIAL_NUMBER[40:25])
		else $error("serial high wrong");
	chk_serial_mid: assert property (rd && addr == 8'hfc |=> rdata == SERIAL_NUMBER[24:9])
		else $error("serial mid wrong");
	chk_serial_low: assert property (rd && addr == 8'hfd |=> rdata == {SERIAL_NUMBER[8:0], 7'h00})
		else $error("serial low wrong");
	chk_maker_code: assert property (rd && addr == 8'hfe |=> rdata == MAKER_CODE)
		else $error("maker code wrong");
	chk_supply_flag: assert property (rd && addr == 8'h02 |=> rdata[11] == $past(supply_low))
		else $error("supply flag wrong");
	chk_cfg_reserved: assert property (rd && addr == 8'h02 |=> rdata[15:14] == 2'b00 && rdata[7:0] == 8'h00)
		else $error("reserved bits set");
	chk_soft_pulse: assert property (wr && addr == 8'h02 && wdata[15] |=> soft_reset ##1 !soft_reset)
		else $error("soft reset pulse wrong");
	chk_soft_clear: assert property (soft_reset |=> {sequential_acquire_select, temp_res_11bit, hum_res} == 4'h0)
		else $error("soft reset kept config");
	chk_res_select: assert property (wr && addr == 8'h02 && !wdata[15] |=> ##1
		{sequential_acquire_select, temp_res_11bit, hum_res} == {$past(wdata[12], 2), $past(wdata[10:8], 2)})
		else $error("control outputs wrong");
endmodule
bind scfg_regs scfg_regs_chk #(.SERIAL_NUMBER(SERIAL_NUMBER), .MAKER_CODE(MAKER_CODE)) u_scfg_regs_chk (.*);

// file: bench/tb_sensor_config_and_id_regs.sv
`timescale 1ns/10ps
module tb_sensor_config_and_id_regs;
	localparam logic [40:0] SER = 41'h123_4567_89ab;
	localparam logic [15:0] MK  = 16'h3c3c; // arbitrary code
	logic clk, resetn, wr, rd, supply_low, soft_reset, heater_enable, irq;
	logic sequential_acquire_select, temp_res_11bit;
	logic [7:0] addr;
	logic [15:0] wdata, rdata, v, d;
	logic [1:0] hum_res;
	int mismatches, total_checks, seed;
	scfg_regs #(.SERIAL_NUMBER(SER), .MAKER_CODE(MK)) u_scfg_regs (.*);
	scfg_host u_scfg_host (.*);
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	task automatic check(input string n, input logic [15:0] s, input logic [15:0] e);
		total_checks++;
		if (s !== e) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic complete_run;
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		#20000;
		mismatches++;
		complete_run;
	end
	initial begin
		resetn = 1'b0;
		supply_low = 1'b0;
		seed = 32'h0000_88e2;
		repeat (10) @(posedge clk);
		resetn <= 1'b1;
		u_scfg_host.get(8'hfb, v); check("ser_high", v, SER[40:25]);
		u_scfg_host.get(8'hfc, v); check("ser_mid", v, SER[24:9]);
		u_scfg_host.get(8'hfd, v); check("ser_low", v, {SER[8:0], 7'h00});
		u_scfg_host.put(8'hfe, ~MK);
		u_scfg_host.get(8'hfe, v); check("maker", v, MK);
		u_scfg_host.get(8'h50, v); check("unmapped", v, 16'h0000);
		$display("test ids done");
		for (int i = 0; i < 12; i++) begin
			d = ($random(seed) & 16'h7c00) | 16'(i % 3) << 8;
			@(posedge clk);
			supply_low <= 1'($random(seed));
			u_scfg_host.put(8'h02, d);
			u_scfg_host.get(8'h02, v);
			check("cfg", v, (d & 16'h3700) | 16'(supply_low) << 11);
			check("outs", {heater_enable, sequential_acquire_select, temp_res_11bit, hum_res},
				{d[13:12], d[10:8]});
		end
		$display("test config done");
		u_scfg_host.put(8'he1, 16'h0003);
		u_scfg_host.put(8'he2, 16'h0001);
		@(posedge clk);
		supply_low <= ~supply_low;
		repeat (3) @(negedge clk);
		check("irq_masked", irq, 16'h0000);
		u_scfg_host.get(8'he0, v); check("status", v, 16'h0002);
		u_scfg_host.get(8'he2, v); check("enable", v, 16'h0001);
		u_scfg_host.put(8'h02, 16'h9700);
		@(negedge clk);
		check("soft_pulse", soft_reset, 16'h0001);
		u_scfg_host.get(8'h02, v); check("cfg_cleared", v, 16'(supply_low) << 11);
		check("irq_raised", irq, 16'h0001);
		u_scfg_host.put(8'he1, 16'h0003);
		repeat (2) @(negedge clk);
		check("irq_cleared", irq, 16'h0000);
		// mid-run reset must drop stored config and the enable mask
		u_scfg_host.put(8'h02, 16'h1600);
		@(posedge clk);
		resetn <= 1'b0;
		repeat (2) @(posedge clk);
		resetn <= 1'b1;
		u_scfg_host.get(8'he2, v); check("enable_rst", v, 16'h0000);
		check("outs_rst", {heater_enable, sequential_acquire_select, temp_res_11bit, hum_res},
			16'h0000);
		$display("test irq done");
		complete_run;
	end
endmodule
